// File: core/rpsf_status_flags.sv
// What this block does
// - lock change since last read sets bit 4 of status one; read clears it.
// - bit 0 of status one shows live receiver lock, never cleared by read.
// - enhanced mode off: bit 3 flags sequence fault, cleared by status one read.
// - enhanced mode on: bit 3 is fault summary, cleared by detail register read.
// - parity flag clears only when parity counts clear, not by status read.
// - bit 1 of status one shows live receiver pass indication.
// - bit 7 of status two flags unsteady line width until read.
// - bit 6 of status two flags line width change, cleared on read.
// - bit 5 of status two flags link coding fault, cleared on read.
// - bit 4 of status two flags packet buffer overflow, cleared on read.
// - bit 3 of status two shows live CSI-2 receive error summary.
// - bit 2 frequency settled, bit 1 input clock missing, both live.
// - bit 0 of status two flags line count change, cleared on read.
// - each receive port has its own copy, selected via port select.
// - two-bit read port field picks which port copy reads return.
// - per-port write enables are driven out on port_write_enable; any combination allowed.
// - bits 7:6 of status one return the selected read port number.
`timescale 1ns/1ps
`default_nettype none
module rpsf_status_flags
  import rpsf_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         reset,
  input  wire logic [7:0]                   host_addr,
  input  wire logic                         host_wr,
  input  wire logic                         host_rd,
  input  wire logic [7:0]                   host_wdata,
  output logic      [7:0]                   host_rdata,
  input  wire logic                         enhanced_ctrl_fault_enable,
  input  wire rpsf_pkg::rpsf_rx_event_type  rx_event [rpsf_pkg::NUM_PORTS],
  output logic      [rpsf_pkg::NUM_PORTS-1:0] port_write_enable,
  output logic      [1:0]                   read_port
);
  import rpsf_pkg::*;

  rpsf_flags_type flags_reg     [NUM_PORTS];
  rpsf_flags_type flags_next    [NUM_PORTS];
  logic [NUM_PORTS-1:0] lock_prev_reg;
  logic [NUM_PORTS-1:0] lock_prev_next;
  logic [7:0]     port_select_reg;
  logic [7:0]     port_select_next;
  logic [7:0]     rdata_reg;
  logic [7:0]     rdata_next;
  logic           read_one;
  logic           read_two;

  // sticky flag: set has priority over clear
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  assign read_port         = port_select_reg[READ_PORT_LSB +: 2];
  assign port_write_enable = port_select_reg[WRITE_EN_LSB +: NUM_PORTS];
  assign read_one          = host_rd && (host_addr == STATUS_ONE_ADDR);
  assign read_two          = host_rd && (host_addr == STATUS_TWO_ADDR);
  assign host_rdata        = rdata_reg;

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      // only the copy returned to the host loses its flags
      logic clr_one;
      logic clr_two;
      logic over;
      clr_one = read_one && (read_port == 2'(p));
      clr_two = read_two && (read_port == 2'(p));
      over    = rx_event[p].parity_fault_count >
                rx_event[p].parity_fault_threshold;
      lock_prev_next[p] = rx_event[p].receiver_locked;
      flags_next[p].lock_change_flag = sticky(flags_reg[p].lock_change_flag,
        rx_event[p].receiver_locked != lock_prev_reg[p], clr_one);
      flags_next[p].ctrl_chan_sequence_fault =
        sticky(flags_reg[p].ctrl_chan_sequence_fault,
               rx_event[p].ctrl_chan_sequence_fault, clr_one);
      flags_next[p].ctrl_chan_fault_summary =
        sticky(flags_reg[p].ctrl_chan_fault_summary,
               rx_event[p].ctrl_chan_any_fault,
               rx_event[p].ctrl_chan_fault_detail_read);
      // level compare keeps the flag low below the threshold
      flags_next[p].parity_fault = sticky(flags_reg[p].parity_fault,
        over, rx_event[p].parity_fault_count_clear);
      flags_next[p].line_width_unsteady =
        sticky(flags_reg[p].line_width_unsteady,
               rx_event[p].line_width_unsteady, clr_two);
      flags_next[p].line_width_changed =
        sticky(flags_reg[p].line_width_changed,
               rx_event[p].line_width_changed, clr_two);
      // a coding fault that drops lock is lost unless counting is set up
      flags_next[p].link_coding_fault =
        sticky(flags_reg[p].link_coding_fault,
               rx_event[p].link_coding_fault, clr_two);
      flags_next[p].buffer_fault = sticky(flags_reg[p].buffer_fault,
        rx_event[p].buffer_overflow, clr_two);
      flags_next[p].line_total_changed =
        sticky(flags_reg[p].line_total_changed,
               rx_event[p].line_total_changed, clr_two);
    end
  end

  always_comb begin
    port_select_next = port_select_reg;
    if (host_wr && host_addr == PORT_SELECT_ADDR) begin
      port_select_next = host_wdata;
    end
  end

  always_comb begin
    rpsf_flags_type    f;
    rpsf_rx_event_type e;
    f          = flags_reg[read_port];
    e          = rx_event[read_port];
    rdata_next = rdata_reg;
    if (host_rd) begin
      unique case (host_addr)
        PORT_SELECT_ADDR: rdata_next = port_select_reg;
        STATUS_ONE_ADDR: begin
          rdata_next = '0;
          rdata_next[S1_PORT_NUM_LSB +: 2] = read_port;
          rdata_next[S1_LOCK_CHG]   = f.lock_change_flag;
          rdata_next[S1_CTRL_FAULT] = enhanced_ctrl_fault_enable ?
            f.ctrl_chan_fault_summary : f.ctrl_chan_sequence_fault;
          rdata_next[S1_PARITY]     = f.parity_fault;
          rdata_next[S1_PASS]       = e.receiver_pass;
          rdata_next[S1_LOCKED]     = e.receiver_locked;
        end
        STATUS_TWO_ADDR: begin
          rdata_next[S2_WIDTH_UNSTEADY] = f.line_width_unsteady;
          rdata_next[S2_WIDTH_CHANGED]  = f.line_width_changed;
          rdata_next[S2_CODING_FAULT]   = f.link_coding_fault;
          rdata_next[S2_BUFFER_FAULT]   = f.buffer_fault;
          rdata_next[S2_CSI_ERROR]      = e.csi_receive_error;
          rdata_next[S2_FREQ_SETTLED]   = e.frequency_settled;
          rdata_next[S2_CLOCK_MISSING]  = e.input_clock_missing;
          rdata_next[S2_TOTAL_CHANGED]  = f.line_total_changed;
        end
        default: rdata_next = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        flags_reg[p] <= FLAGS_RESET;
      end
      lock_prev_reg   <= '0;
      port_select_reg <= PORT_SELECT_RESET;
      rdata_reg       <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        flags_reg[p] <= flags_next[p];
      end
      lock_prev_reg   <= lock_prev_next;
      port_select_reg <= port_select_next;
      rdata_reg       <= rdata_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_lock_change_sets;
    $changed(rx_event[1].receiver_locked) |=> flags_reg[1].lock_change_flag;
  endproperty
  a_lock_change_sets: assert property (p_lock_change_sets)
    else $error("lock change did not set the flag");

  property p_read_clears_lock_change;
    (read_one && read_port == 2'd1 && !$changed(rx_event[1].receiver_locked))
      |=> !flags_reg[1].lock_change_flag;
  endproperty
  a_read_clears_lock_change: assert property (p_read_clears_lock_change)
    else $error("status one read left lock change flag set");

  property p_live_lock;
    read_one |=> host_rdata[S1_LOCKED] ==
      $past(rx_event[read_port].receiver_locked);
  endproperty
  a_live_lock: assert property (p_live_lock)
    else $error("lock bit does not follow receiver lock");

  property p_seq_fault_read;
    (flags_reg[0].ctrl_chan_sequence_fault && !enhanced_ctrl_fault_enable
      && read_one && read_port == 2'd0) |=> host_rdata[S1_CTRL_FAULT];
  endproperty
  a_seq_fault_read: assert property (p_seq_fault_read)
    else $error("sequence fault not reported");

  property p_summary_survives_read;
    (flags_reg[0].ctrl_chan_fault_summary && read_one
      && !rx_event[0].ctrl_chan_fault_detail_read)
      |=> flags_reg[0].ctrl_chan_fault_summary;
  endproperty
  a_summary_survives_read: assert property (p_summary_survives_read)
    else $error("status read cleared the fault summary");

  property p_parity_sticky;
    (flags_reg[0].parity_fault && !rx_event[0].parity_fault_count_clear)
      |=> flags_reg[0].parity_fault;
  endproperty
  a_parity_sticky: assert property (p_parity_sticky)
    else $error("parity flag cleared without count clear");

  property p_event_wins;
    (read_two && read_port == 2'd0 && rx_event[0].buffer_overflow)
      |=> flags_reg[0].buffer_fault;
  endproperty
  a_event_wins: assert property (p_event_wins)
    else $error("overflow coinciding with read was lost");

  property p_other_port_kept;
    (read_two && read_port != 2'd3 && flags_reg[3].line_width_changed)
      |=> flags_reg[3].line_width_changed;
  endproperty
  a_other_port_kept: assert property (p_other_port_kept)
    else $error("read of another port cleared this copy");

  property p_port_number;
    read_one |=> host_rdata[S1_PORT_NUM_LSB +: 2] == $past(read_port);
  endproperty
  a_port_number: assert property (p_port_number)
    else $error("port number field wrong");

endmodule : rpsf_status_flags
`default_nettype wire

// File: core/rpsf_pkg.sv
package rpsf_pkg;

  localparam int          NUM_PORTS        = 4;
  localparam logic [7:0]  PORT_SELECT_ADDR = 8'h4c;
  localparam logic [7:0]  STATUS_ONE_ADDR  = 8'h4d;
  localparam logic [7:0]  STATUS_TWO_ADDR  = 8'h4e;
  localparam logic [7:0]  PORT_SELECT_RESET = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

  // port select field layout
  localparam int READ_PORT_LSB   = 4;
  localparam int WRITE_EN_LSB    = 0;

  // first status register bit positions
  localparam int S1_PORT_NUM_LSB = 6;
  localparam int S1_LOCK_CHG     = 4;
  localparam int S1_CTRL_FAULT   = 3;
  localparam int S1_PARITY       = 2;
  localparam int S1_PASS         = 1;
  localparam int S1_LOCKED       = 0;

  // second status register bit positions
  localparam int S2_WIDTH_UNSTEADY = 7;
  localparam int S2_WIDTH_CHANGED  = 6;
  localparam int S2_CODING_FAULT   = 5;
  localparam int S2_BUFFER_FAULT   = 4;
  localparam int S2_CSI_ERROR      = 3;
  localparam int S2_FREQ_SETTLED   = 2;
  localparam int S2_CLOCK_MISSING  = 1;
  localparam int S2_TOTAL_CHANGED  = 0;

  // per-port conditions from the receiver, same clock domain
  typedef struct packed {
    logic        receiver_locked;
    logic        ctrl_chan_sequence_fault;
    logic        ctrl_chan_any_fault;
    logic        ctrl_chan_fault_detail_read;
    logic [15:0] parity_fault_count;
    logic [15:0] parity_fault_threshold;
    logic        parity_fault_count_clear;
    logic        receiver_pass;
    logic        line_width_unsteady;
    logic        line_width_changed;
    logic        link_coding_fault;
    logic        buffer_overflow;
    logic        csi_receive_error;
    logic        frequency_settled;
    logic        input_clock_missing;
    logic        line_total_changed;
  } rpsf_rx_event_type;

  typedef struct packed {
    logic lock_change_flag;
    logic ctrl_chan_sequence_fault;
    logic ctrl_chan_fault_summary;
    logic parity_fault;
    logic line_width_unsteady;
    logic line_width_changed;
    logic link_coding_fault;
    logic buffer_fault;
    logic line_total_changed;
  } rpsf_flags_type;

  localparam rpsf_flags_type FLAGS_RESET = '0;

endpackage : rpsf_pkg

// File: tb/rpsf_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpsf_rx_model
  import rpsf_pkg::*;
(
  input  wire logic                        mclk,
  output var rpsf_pkg::rpsf_rx_event_type rx_event [rpsf_pkg::NUM_PORTS]
);
  rpsf_rx_event_type level_reg [NUM_PORTS];
  rpsf_rx_event_type pulse_reg [NUM_PORTS];
  initial begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      level_reg[p] = '0;
      pulse_reg[p] = '0;
    end
  end
  // pulses only add flag bits on top of the receiver's standing levels
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      rx_event[p] = level_reg[p] | pulse_reg[p];
    end
  end
  task automatic set_level(input int p, input rpsf_rx_event_type v);
    @(posedge mclk);
    level_reg[p] <= v;
  endtask : set_level
  // len above one stands for a slow receiver holding its event line
  task automatic pulse(input int p, input rpsf_rx_event_type v, input int len);
    @(posedge mclk);
    pulse_reg[p] <= v;
    repeat (len) @(posedge mclk);
    pulse_reg[p] <= '0;
  endtask : pulse
endmodule : rpsf_rx_model
`default_nettype wire

// File: tb/test_rpsf_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_rpsf_status_flags;
  import rpsf_pkg::*;
  logic                 mclk, reset, host_wr, host_rd, enh;
  logic [7:0]           host_addr, host_wdata, host_rdata, rd_val;
  logic [NUM_PORTS-1:0] pwe;
  logic [1:0]           rport;
  rpsf_rx_event_type    rx_event [NUM_PORTS];
  rpsf_rx_event_type    ev;
  int                   err_count = 0, n_checks = 0, cycles = 0;
  rpsf_rx_model PARTNER (.mclk(mclk), .rx_event(rx_event));
  rpsf_status_flags DUT (.mclk(mclk), .reset(reset), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .enhanced_ctrl_fault_enable(enh),
    .rx_event(rx_event), .port_write_enable(pwe), .read_port(rport));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    host_wr    <= 1'b1;
    host_addr  <= a;
    host_wdata <= d;
    @(posedge mclk);
    host_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    host_rd   <= 1'b1;
    host_addr <= a;
    @(posedge mclk);
    host_rd <= 1'b0;
    #1 rd_val = host_rdata;
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a, exp);
    rd(a);
    chk(nm, exp, rd_val);
  endtask : rchk
  task automatic sel(input logic [1:0] p);
    wr(PORT_SELECT_ADDR, {2'b00, p, 4'hf});
  endtask : sel
  task automatic t_select;
    chk("read_port", 8'h00, {6'h00, rport});
    chk("write_en", 8'h00, {4'h0, pwe});
    rchk("unmapped", 8'h4f, UNMAPPED_READ);
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr(PORT_SELECT_ADDR, 8'((p << 4) | (1 << (3 - p))));
      chk("read_port", 8'(p), {6'h00, rport});
      chk("write_en", 8'(1 << (3 - p)), {4'h0, pwe});
      rchk("port_num", STATUS_ONE_ADDR, 8'(p << 6));
    end
    wr(PORT_SELECT_ADDR, 8'h2b);
    chk("write_en", 8'h0b, {4'h0, pwe});
  endtask : t_select
  task automatic t_lock;
    ev = '0;
    ev.receiver_locked = 1'b1;
    ev.receiver_pass = 1'b1;
    PARTNER.set_level(1, ev);
    sel(2'd1);
    rchk("sts1", STATUS_ONE_ADDR, 8'h53);
    wr(STATUS_ONE_ADDR, 8'hff);
    rchk("sts1", STATUS_ONE_ADDR, 8'h43);
    PARTNER.set_level(1, '0);
    rchk("sts1", STATUS_ONE_ADDR, 8'h50);
    sel(2'd0);
    rchk("sts1", STATUS_ONE_ADDR, 8'h00);
  endtask : t_lock
  task automatic t_status_two;
    ev = '0;
    ev.csi_receive_error = 1'b1;
    ev.input_clock_missing = 1'b1;
    ev.frequency_settled = 1'b1;
    PARTNER.set_level(2, ev);
    ev.line_width_unsteady = 1'b1;
    ev.line_width_changed = 1'b1;
    // coding faults arrive with lock kept, as with counting enabled
    ev.link_coding_fault = 1'b1;
    ev.buffer_overflow = 1'b1;
    ev.line_total_changed = 1'b1;
    PARTNER.pulse(2, ev, 3);
    ev = '0;
    ev.line_width_changed = 1'b1;
    PARTNER.pulse(3, ev, 1);
    sel(2'd2);
    rchk("sts2", STATUS_TWO_ADDR, 8'hff);
    rchk("sts2", STATUS_TWO_ADDR, 8'h0e);
    sel(2'd3);
    rchk("sts2", STATUS_TWO_ADDR, 8'h40);
    ev = '0;
    ev.buffer_overflow = 1'b1;
    sel(2'd0);
    fork
      rd(STATUS_TWO_ADDR);
      PARTNER.pulse(0, ev, 1);
    join
    rchk("sts2", STATUS_TWO_ADDR, 8'h10);
  endtask : t_status_two
  task automatic t_ctrl;
    sel(2'd0);
    ev = '0;
    ev.ctrl_chan_sequence_fault = 1'b1;
    PARTNER.pulse(0, ev, 1);
    rchk("sts1", STATUS_ONE_ADDR, 8'h08);
    rchk("sts1", STATUS_ONE_ADDR, 8'h00);
    @(posedge mclk);
    enh <= 1'b1;
    ev = '0;
    ev.ctrl_chan_any_fault = 1'b1;
    PARTNER.pulse(0, ev, 1);
    rchk("sts1", STATUS_ONE_ADDR, 8'h08);
    rchk("sts1", STATUS_ONE_ADDR, 8'h08);
    ev = '0;
    ev.ctrl_chan_fault_detail_read = 1'b1;
    PARTNER.pulse(0, ev, 1);
    rchk("sts1", STATUS_ONE_ADDR, 8'h00);
  endtask : t_ctrl
  task automatic t_parity;
    ev = '0;
    ev.parity_fault_count = 16'h0005;
    ev.parity_fault_threshold = 16'h0005;
    PARTNER.set_level(0, ev);
    rchk("sts1", STATUS_ONE_ADDR, 8'h00);
    ev.parity_fault_count = 16'h0006;
    PARTNER.set_level(0, ev);
    rchk("sts1", STATUS_ONE_ADDR, 8'h04);
    ev.parity_fault_count = 16'h0000;
    PARTNER.set_level(0, ev);
    rchk("sts1", STATUS_ONE_ADDR, 8'h04);
    ev.parity_fault_count_clear = 1'b1;
    PARTNER.pulse(0, ev, 1);
    rchk("sts1", STATUS_ONE_ADDR, 8'h00);
  endtask : t_parity
  initial begin
    reset = 1'b1;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
    enh = 1'b0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_select();
    t_lock();
    t_status_two();
    t_ctrl();
    t_parity();
    print_verdict();
  end
endmodule : test_rpsf_status_flags
`default_nettype wire
